/* hw/lsc_shutdown_ctrl.sv */
// Functional notes
// - a software shutdown bit of 0 puts the device into software shutdown.
// - in software shutdown every output current source is off.
// - in software shutdown the registers stay reachable over the serial port.
// - a low shutdown pin puts the device into hardware shutdown.
// - in hardware shutdown all current sources are off whatever the registers hold.
// - a high shutdown pin takes the device out of hardware shutdown.
// - each rising edge of the shutdown pin returns the serial interface to idle.
// - that serial interface reset leaves every register value unchanged.
// - with the shutdown pin low, register reads and writes still work.
// - stored register data is kept through either shutdown mode.
`timescale 1ns/1ps
`default_nettype none

`include "lsc_cfg.svh"

module lsc_shutdown_ctrl (
  // clock, reset and enable
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  // shutdown controls
  input  wire logic                   shutdown_pin_n,
  input  wire logic                   software_shutdown_bit,
  // per-channel drive requests from the pwm logic
  input  wire logic [`LSC_NUM_CH-1:0] ch_request,
  // current source enables
  output logic      [`LSC_NUM_CH-1:0] out_en,
  // serial interface idle reset, one-cycle pulse
  output logic                        spi_rst,
  // register file access permit, never a clear
  output logic                        reg_acc,
  // status
  output logic                        sw_shdn,
  output logic                        hw_shdn,
  output logic                        running
);

  // ************************************************************
  // pin tracking
  // ************************************************************
  lsc_pin_if pin_bus ();

  lsc_pin_edge u_pin_edge (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .ce             (ce),
    .shutdown_pin_n (shutdown_pin_n),
    .pin            (pin_bus.tracker)
  );

  // ************************************************************
  // state
  // ************************************************************
  lsc_pkg::lsc_ctrl_state_t st_q;
  lsc_pkg::lsc_ctrl_state_t st_d;

  logic                   run_ok;
  logic [`LSC_NUM_CH-1:0] en_next;

  // both conditions needed to drive current
  assign run_ok = software_shutdown_bit & pin_bus.pin_high;

  // per-channel gating of the drive requests
  genvar ch;
  generate
    for (ch = 0; ch < `LSC_NUM_CH; ch = ch + 1) begin : g_ch
      assign en_next[ch] = run_ok & ch_request[ch];
    end
  endgenerate

  // next state
  always_comb begin
    st_d         = st_q;
    st_d.sw_shdn = ~software_shutdown_bit;
    st_d.hw_shdn = ~pin_bus.pin_high;
    st_d.out_en  = en_next;
    // idle the serial engine only; registers untouched
    st_d.spi_rst = pin_bus.rise;
    // registers reachable in every mode after reset
    st_d.reg_acc = 1'h1;
    case (st_q.mode)
      lsc_pkg::LSC_MODE_RESET: begin
        st_d.mode = lsc_pkg::LSC_MODE_SHUTDOWN;
      end
      lsc_pkg::LSC_MODE_SHUTDOWN: begin
        if (run_ok) begin
          st_d.mode = lsc_pkg::LSC_MODE_RUN;
        end
      end
      lsc_pkg::LSC_MODE_RUN: begin
        if (!run_ok) begin
          st_d.mode = lsc_pkg::LSC_MODE_SHUTDOWN;
        end
      end
      default: begin
        st_d.mode = lsc_pkg::LSC_MODE_SHUTDOWN;
      end
    endcase
    // run status registered alongside the mode
    st_d.running = (st_d.mode == lsc_pkg::LSC_MODE_RUN);
  end

  // state register, frozen while ce is low
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q.mode    <= lsc_pkg::LSC_MODE_RESET;
      st_q.out_en  <= `LSC_RST_OUT_EN;
      st_q.spi_rst <= `LSC_RST_SPI_RST;
      st_q.sw_shdn <= `LSC_RST_SW_SHDN;
      st_q.hw_shdn <= `LSC_RST_HW_SHDN;
      st_q.reg_acc <= `LSC_RST_REG_ACC;
      st_q.running <= `LSC_RST_RUN;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // outputs, straight from flip-flops
  // ************************************************************
  assign out_en  = st_q.out_en;
  assign spi_rst = st_q.spi_rst;
  assign reg_acc = st_q.reg_acc;
  assign sw_shdn = st_q.sw_shdn;
  assign hw_shdn = st_q.hw_shdn;
  assign running = st_q.running;

endmodule

`default_nettype wire

/* hw/lsc_cfg.svh */
`ifndef LSC_CFG_SVH
`define LSC_CFG_SVH

// ************************************************************
// channel count and reset values
// ************************************************************
`define LSC_NUM_CH          18
`define LSC_RST_OUT_EN      18'h00000
`define LSC_RST_PIN_PREV    1'h1
`define LSC_RST_SPI_RST     1'h0
`define LSC_RST_SW_SHDN     1'h1
`define LSC_RST_HW_SHDN     1'h1
`define LSC_RST_REG_ACC     1'h0
`define LSC_RST_RUN         1'h0

`endif

/* hw/lsc_pkg.sv */
`include "lsc_cfg.svh"

package lsc_pkg;

  // ************************************************************
  // operating modes of the shutdown controller
  // ************************************************************
  typedef enum logic [1:0] {
    LSC_MODE_RESET,
    LSC_MODE_SHUTDOWN,
    LSC_MODE_RUN
  } lsc_mode_t;

  // state of the pin edge tracker
  typedef struct packed {
    logic pin_prev;
    logic pin_high;
    logic rise;
  } lsc_edge_state_t;

  // state of the main controller
  typedef struct packed {
    lsc_mode_t               mode;
    logic [`LSC_NUM_CH-1:0]  out_en;
    logic                    spi_rst;
    logic                    sw_shdn;
    logic                    hw_shdn;
    logic                    reg_acc;
    logic                    running;
  } lsc_ctrl_state_t;

endpackage

/* hw/lsc_pin_if.sv */
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// shutdown pin status between tracker and controller
// ************************************************************
interface lsc_pin_if;
  logic pin_high;
  logic rise;

  modport tracker (output pin_high, output rise);
  modport ctrl    (input  pin_high, input  rise);
endinterface

`default_nettype wire

/* hw/lsc_pin_edge.sv */
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// shutdown pin level and rising edge tracker
// ************************************************************
module lsc_pin_edge (
  // clock and reset
  input  wire logic  mclk,
  input  wire logic  rst_n,
  input  wire logic  ce,
  // shutdown pin, synchronous to mclk
  input  wire logic  shutdown_pin_n,
  // status towards controller
  lsc_pin_if.tracker pin
);

  lsc_pkg::lsc_edge_state_t st_q;
  lsc_pkg::lsc_edge_state_t st_d;

  // next state: level copy and one-cycle rise pulse
  always_comb begin
    st_d          = st_q;
    st_d.pin_prev = shutdown_pin_n;
    st_d.pin_high = shutdown_pin_n;
    st_d.rise     = shutdown_pin_n & ~st_q.pin_prev;
  end

  // state register, frozen while ce is low
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q.pin_prev <= `LSC_RST_PIN_PREV;
      st_q.pin_high <= 1'h0;
      st_q.rise     <= 1'h0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign pin.pin_high = st_q.pin_high;
  assign pin.rise     = st_q.rise;

endmodule

`default_nettype wire

/* hw/_unused_guard_placeholder.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* dv/lsc_shutdown_ctrl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lsc_cfg.svh"
// ****
// shutdown checks
// ****
module lsc_shutdown_ctrl_assertions (
  // clock and reset
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic                   ce,
  // controls
  input wire logic                   shutdown_pin_n,
  input wire logic                   software_shutdown_bit,
  input wire logic [`LSC_NUM_CH-1:0] ch_request,
  // watched outputs
  input wire logic [`LSC_NUM_CH-1:0] out_en,
  input wire logic                   spi_rst,
  input wire logic                   reg_acc,
  input wire logic                   sw_shdn,
  input wire logic                   hw_shdn
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n || !ce);
  // pin seen low, then high
  sequence pin_rise; !shutdown_pin_n ##1 shutdown_pin_n; endsequence
  sequence one_pulse; spi_rst ##1 !spi_rst; endsequence
  a_sw_off: assert property (!software_shutdown_bit |=> sw_shdn && out_en == '0)
    else $error("outputs on in software shutdown");
  a_sw_on: assert property (software_shutdown_bit |=> !sw_shdn)
    else $error("software shutdown stuck");
  a_hw_off: assert property (!shutdown_pin_n |=> ##1 hw_shdn && out_en == '0)
    else $error("outputs on with pin low");
  a_hw_exit: assert property (shutdown_pin_n |=> ##1 !hw_shdn)
    else $error("hardware shutdown stuck");
  a_rise_pulse: assert property (pin_rise |=> ##1 one_pulse)
    else $error("no idle reset pulse on rise");
  a_no_spurious: assert property (spi_rst |-> $past(shutdown_pin_n, 2) && !$past(shutdown_pin_n, 3))
    else $error("idle reset without rise");
  a_run_gate: assert property (out_en != '0 |-> !sw_shdn && !hw_shdn)
    else $error("outputs on in shutdown");
  a_out_follow: assert property (!sw_shdn && !hw_shdn |-> out_en == $past(ch_request))
    else $error("outputs differ from request");
  a_reg_access: assert property (rst_n |=> reg_acc)
    else $error("register access blocked");
endmodule
bind lsc_shutdown_ctrl lsc_shutdown_ctrl_assertions u_chk (.mclk, .rst_n, .ce, .shutdown_pin_n,
  .software_shutdown_bit, .ch_request, .out_en, .spi_rst, .reg_acc, .sw_shdn, .hw_shdn);
`default_nettype wire

/* dv/lsc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// host driving pin and control bit
// ****
module lsc_host_model (
  // clock
  input wire logic mclk,
  // towards the device
  output logic     shutdown_pin_n,
  output logic     software_shutdown_bit
);
  // pin released high, bit at its reset value
  initial begin
    shutdown_pin_n = 1'h1;
    software_shutdown_bit = 1'h0;
  end
  // change both just after an edge; pin written first, then the bit, in the same step
  task automatic drive(input logic pin, input logic en);
    @(posedge mclk);
    #1;
    shutdown_pin_n = pin;
    software_shutdown_bit = en;
  endtask
endmodule
`default_nettype wire

/* dv/lsc_shutdown_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lsc_cfg.svh"
module lsc_shutdown_ctrl_tb;
  logic                   mclk = 1'h0;
  logic                   rst_n = 1'h0;
  logic                   ce = 1'h1;
  logic [`LSC_NUM_CH-1:0] req = '0;
  wire logic              pin_n;
  wire logic              sw_bit;
  logic [`LSC_NUM_CH-1:0] out_en;
  logic                   spi_rst, reg_acc, sw_shdn, hw_shdn, running;
  int                     failures = 0;
  int                     check_count = 0;
  lsc_host_model host (.mclk(mclk), .shutdown_pin_n(pin_n), .software_shutdown_bit(sw_bit));
  lsc_shutdown_ctrl dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .shutdown_pin_n(pin_n),
    .software_shutdown_bit(sw_bit), .ch_request(req), .out_en(out_en), .spi_rst(spi_rst),
    .reg_acc(reg_acc), .sw_shdn(sw_shdn), .hw_shdn(hw_shdn), .running(running));
  // 100 MHz clock
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [`LSC_NUM_CH-1:0] seen, input logic [`LSC_NUM_CH-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic test_soft;
    host.drive(1'h1, 1'h0);
    req = 18'h3FFFF;
    step(3);
    chk(out_en, '0);
    chk(sw_shdn, 1'h1);
    chk(reg_acc, 1'h1);
    host.drive(1'h1, 1'h1);
    step(1);
    chk(out_en, 18'h3FFFF);
    chk(sw_shdn, 1'h0);
    $display("test_soft done");
  endtask
  task automatic test_hard;
    req = 18'h2A5A5;
    host.drive(1'h0, 1'h1);
    step(2);
    chk(hw_shdn, 1'h1);
    chk(out_en, '0);
    chk(reg_acc, 1'h1);
    host.drive(1'h0, 1'h1);
    host.drive(1'h1, 1'h1);
    step(1);
    chk(spi_rst, 1'h0);
    step(1);
    chk(spi_rst, 1'h1);
    chk(hw_shdn, 1'h0);
    chk(out_en, 18'h2A5A5);
    step(1);
    chk(spi_rst, 1'h0);
    chk(running, 1'h1);
    $display("test_hard done");
  endtask
  // clock enable low freezes state, release lets it move on
  task automatic test_freeze;
    ce = 1'h0;
    host.drive(1'h1, 1'h0);
    step(2);
    chk(sw_shdn, 1'h0);
    chk(out_en, 18'h2A5A5);
    ce = 1'h1;
    step(1);
    chk(sw_shdn, 1'h1);
    chk(out_en, '0);
    $display("test_freeze done");
  endtask
  // reset, then the scenarios
  initial begin
    step(2);
    rst_n = 1'h1;
    test_soft();
    test_hard();
    test_freeze();
    finish_test();
  end
  // watchdog
  initial begin
    #2000;
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
